// File: include/slsl_pkg.sv
package slsl_pkg;
	// clock rate and derived timing
	localparam int unsigned CLK_HZ = 20_000_000;
	// power-off time that clears an overload latch, in seconds
	localparam int unsigned OVL_RESET_S = 5;
	// averaging depth of one analogue read
	localparam int unsigned ADC_SAMPLES = 16;
	localparam int unsigned ADC_SHIFT = 4;
	localparam int unsigned ADC_W = 8;
	localparam int unsigned ADC_LEVELS = 256;
	// millivolts per code step
	localparam int unsigned ADC_STEP_MV = 20;
	localparam int unsigned ACC_W = ADC_W + ADC_SHIFT;
	localparam int unsigned ANA_N = 6;
	localparam int unsigned POS_W = 32;
	// width of the step clock pulse in cycles
	localparam int unsigned PULSE_CYC = 4;
	localparam logic [2:0] PULSE_LAST = 3'h3;
	localparam logic [3:0] SAMPLE_LAST = 4'hf;
	typedef enum logic [1:0] {
		SLSL_A_IDLE = 2'b00,
		SLSL_A_REQ = 2'b01,
		SLSL_A_WAIT = 2'b10,
		SLSL_A_DONE = 2'b11
	} slsl_adc_e;
endpackage

// File: core/slsl_step_limit_stop.sv
`timescale 1ns/1ps
// Behaviour
// R1 - one step clock pulse per commanded step
// R2 - overload switches output off, sets indicator
// R3 - overload stays latched until power-on reset
// R4 - analogue read averages sixteen conversions
// R5 - results are eight-bit codes, 20 mV steps
// R6 - analogue inputs always readable as digital
// R7 - ccw motion stops on ccw limit high
// R8 - cw motion stops on cw limit high
// R9 - limit stop skips deceleration ramp
// R10 - limit stop leaves sequencer running
// R11 - stop input low freezes program and steps
// R12 - release resumes, position counter kept
// R13 - stop input halt has no ramp
// R14 - limit, stop, digital inputs double-synchronised
module slsl_step_limit_stop #(
	parameter int unsigned ANA_N = slsl_pkg::ANA_N,
	parameter int unsigned POS_W = slsl_pkg::POS_W
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic step_req_i,
	input wire logic dir_cw_i,
	input wire logic limit_clockwise_i,
	input wire logic limit_counter_clockwise_i,
	input wire logic stop_n_i,
	input wire logic overload_i,
	input wire logic [ANA_N-1:0] ana_dig_i,
	input wire logic ana_rd_i,
	input wire logic [2:0] ana_sel_i,
	input wire logic [slsl_pkg::ADC_W-1:0] adc_data_i,
	input wire logic adc_valid_i,
	output logic step_clk_o,
	output logic step_taken_o,
	output logic step_blocked_o,
	output logic overload_o,
	output logic prog_run_o,
	output logic [POS_W-1:0] position_o,
	output logic [ANA_N-1:0] dig_o,
	output logic adc_start_o,
	output logic [2:0] adc_chan_o,
	output logic [slsl_pkg::ADC_W-1:0] ana_result_o,
	output logic ana_done_o
);
	import slsl_pkg::*;

	logic cw_s1_r, cw_s2_r, ccw_s1_r, ccw_s2_r, stop_s1_r, stop_s2_r;
	logic [ANA_N-1:0] dig_s1_r;
	logic [2:0] pulse_cnt_r;
	logic pulse_busy_r;
	logic pulse_end;
	logic limit_hit;
	logic step_go;
	slsl_adc_e adc_st_r;
	slsl_adc_e adc_st_nxt;
	logic read_go;
	logic smp_take;
	logic last_smp;
	logic [3:0] smp_cnt_r;
	logic [ACC_W-1:0] acc_r;

	// clockwise limit: two flops, the first stage feeds only the second
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cw_s1_r <= 1'b0;
			cw_s2_r <= 1'b0;
		end else begin
			cw_s1_r <= limit_clockwise_i; // R14
			cw_s2_r <= cw_s1_r;
		end
	end

	// counter-clockwise limit: same two-flop chain, two cycles of latency
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ccw_s1_r <= 1'b0;
			ccw_s2_r <= 1'b0;
		end else begin
			ccw_s1_r <= limit_counter_clockwise_i; // R14
			ccw_s2_r <= ccw_s1_r;
		end
	end

	// stop input resets to released so a reset alone never freezes the sequencer
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stop_s1_r <= 1'b1;
			stop_s2_r <= 1'b1;
		end else begin
			stop_s1_r <= stop_n_i; // R14
			stop_s2_r <= stop_s1_r;
		end
	end

	// digital view of each analogue pin, no mode switch needed
	genvar g;
	generate
		for (g = 0; g < ANA_N; g++) begin : g_dig
			always_ff @(posedge mclk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					dig_s1_r[g] <= 1'b0;
					dig_o[g] <= 1'b0;
				end else begin
					dig_s1_r[g] <= ana_dig_i[g]; // R14
					dig_o[g] <= dig_s1_r[g]; // R6
				end
			end
		end
	endgenerate

	// only the limit in the direction of travel counts; the other is ignored
	always_comb begin
		limit_hit = ccw_s2_r; // R7
		if (dir_cw_i) begin
			limit_hit = cw_s2_r; // R8
		end
	end

	// a step is issued only when not frozen, not limited, not overloaded
	assign step_go = step_req_i && stop_s2_r && !limit_hit && !overload_o && !pulse_busy_r;
	// last cycle of a running pulse
	assign pulse_end = pulse_busy_r && (pulse_cnt_r == PULSE_LAST);

	// sequencer runs unless stop input held low; limits do not touch it
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prog_run_o <= 1'b0;
		end else begin
			prog_run_o <= stop_s2_r; // R11 R10
		end
	end

	// overload latch: only arst clears it, i.e. power-on reset after supply removal
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overload_o <= 1'b0;
		end else if (overload_i) begin
			overload_o <= 1'b1; // R2 R3
		end
	end

	// busy covers the whole pulse, so a request cannot retrigger it midway
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pulse_busy_r <= 1'b0;
		end else if (overload_o || overload_i) begin
			pulse_busy_r <= 1'b0;
		end else if (step_go) begin
			pulse_busy_r <= 1'b1;
		end else if (pulse_end) begin
			pulse_busy_r <= 1'b0;
		end
	end

	// width counter runs only inside a pulse and holds at its last value
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pulse_cnt_r <= 3'h0;
		end else if (overload_o || overload_i || step_go) begin
			pulse_cnt_r <= 3'h0;
		end else if (pulse_busy_r && !pulse_end) begin
			pulse_cnt_r <= pulse_cnt_r + 3'h1;
		end
	end

	// step clock: cut at once on overload, otherwise one fixed pulse per step
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			step_clk_o <= 1'b0;
		end else if (overload_o || overload_i) begin
			step_clk_o <= 1'b0; // R2
		end else if (step_go) begin
			step_clk_o <= 1'b1; // R1
		end else if (pulse_end) begin
			step_clk_o <= 1'b0;
		end
	end

	// accepted-step strobe; a pulse already started is cut short by overload
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			step_taken_o <= 1'b0;
		end else begin
			step_taken_o <= step_go && !overload_i;
		end
	end

	// refused requests are dropped, never deferred into a ramp
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			step_blocked_o <= 1'b0;
		end else begin
			step_blocked_o <= step_req_i && (!stop_s2_r || limit_hit); // R9 R13 R11
		end
	end

	// position counter follows issued steps; held, never cleared, while frozen
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			position_o <= '0;
		end else if (step_go && !overload_i) begin
			position_o <= dir_cw_i ? position_o + 1'b1 : position_o - 1'b1; // R12
		end
	end

	// read sequencing strobes; a read request is only taken from idle
	assign read_go = (adc_st_r == SLSL_A_IDLE) && ana_rd_i;
	assign smp_take = (adc_st_r == SLSL_A_WAIT) && adc_valid_i;
	assign last_smp = (smp_cnt_r == SAMPLE_LAST);

	// next state: one start per sample, sixteen samples, then one done cycle
	always_comb begin
		adc_st_nxt = adc_st_r;
		unique case (adc_st_r)
			SLSL_A_IDLE: begin
				if (ana_rd_i) begin
					adc_st_nxt = SLSL_A_WAIT;
				end
			end
			SLSL_A_REQ: begin
				adc_st_nxt = SLSL_A_WAIT;
			end
			SLSL_A_WAIT: begin
				if (adc_valid_i) begin
					adc_st_nxt = last_smp ? SLSL_A_DONE : SLSL_A_REQ;
				end
			end
			SLSL_A_DONE: begin
				adc_st_nxt = SLSL_A_IDLE;
			end
		endcase
	end

	// read state register
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			adc_st_r <= SLSL_A_IDLE;
		end else begin
			adc_st_r <= adc_st_nxt;
		end
	end

	// sample counter: cleared on a new read, stops at the last sample
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			smp_cnt_r <= 4'h0;
		end else if (read_go) begin
			smp_cnt_r <= 4'h0;
		end else if (smp_take && !last_smp) begin
			smp_cnt_r <= smp_cnt_r + 4'h1;
		end
	end

	// sum is wide enough for sixteen full-scale codes, so it never wraps
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc_r <= '0;
		end else if (read_go) begin
			acc_r <= '0;
		end else if (smp_take) begin
			acc_r <= acc_r + {{ADC_SHIFT{1'b0}}, adc_data_i}; // R4
		end
	end

	// channel is captured once per read and held for all sixteen samples
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			adc_chan_o <= 3'h0;
		end else if (read_go) begin
			adc_chan_o <= ana_sel_i;
		end
	end

	// conversion request: on the read itself and once after each sample but the last
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			adc_start_o <= 1'b0;
		end else begin
			adc_start_o <= read_go || (adc_st_r == SLSL_A_REQ);
		end
	end

	// mean is the sum shifted by four; truncation keeps it inside 8 bits
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ana_result_o <= 8'h00;
			ana_done_o <= 1'b0;
		end else begin
			ana_done_o <= (adc_st_r == SLSL_A_DONE);
			if (adc_st_r == SLSL_A_DONE) begin
				ana_result_o <= acc_r[ACC_W-1:ADC_SHIFT]; // R4 R5
			end
		end
	end
endmodule

// File: verification/slsl_chk.sv
`timescale 1ns/1ps
module slsl_chk (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic step_req_i,
	input wire logic dir_cw_i,
	input wire logic limit_clockwise_i,
	input wire logic limit_counter_clockwise_i,
	input wire logic stop_n_i,
	input wire logic overload_i,
	input wire logic adc_valid_i,
	input wire logic step_clk_o,
	input wire logic step_taken_o,
	input wire logic overload_o,
	input wire logic prog_run_o,
	input wire logic adc_start_o,
	input wire logic ana_done_o
);
	// every check runs on the system clock and rests during reset
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	a_pulse_starts: assert property ($rose(step_clk_o) |-> step_taken_o)
		else $error("step pulse without accepted step");
	a_pulse_width: assert property ($rose(step_clk_o) |->
		step_clk_o[*4] ##1 !step_clk_o or ##[1:4] overload_o) else $error("step pulse width");
	a_ovl_sets: assert property (overload_i |=> overload_o) else $error("overload missed");
	a_ovl_cuts: assert property (overload_o |-> !step_clk_o) else $error("output live");
	a_ovl_holds: assert property (overload_o |=> overload_o) else $error("overload cleared");
	// limit pins reach the decision two edges late through the synchroniser
	a_cw_limit_stop: assert property (step_req_i && dir_cw_i &&
		$past(limit_clockwise_i, 2) |=> !step_taken_o) else $error("cw limit ignored");
	a_ccw_limit_stop: assert property (step_req_i && !dir_cw_i &&
		$past(limit_counter_clockwise_i, 2) |=> !step_taken_o) else $error("ccw limit ignored");
	a_stop_blocks: assert property (step_req_i && !$past(stop_n_i, 2) |=> !step_taken_o)
		else $error("step during stop");
	a_stop_freeze: assert property ((!stop_n_i)[*4] |-> !prog_run_o) else $error("not frozen");
	a_stop_release: assert property (stop_n_i[*4] |-> prog_run_o) else $error("not resumed");
	a_adc_next: assert property (adc_valid_i |-> ##2 (adc_start_o || ana_done_o))
		else $error("sample sequence stalled");
endmodule
bind slsl_step_limit_stop slsl_chk u_chk (.*);

// File: verification/slsl_adc_model.sv
`timescale 1ns/1ps
module slsl_adc_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [7:0] code_i,
	output logic valid_o = 1'b0,
	output logic [7:0] data_o = 8'h00
);
	logic [2:0] cnt_r = 3'h0;
	// latency follows the code, so prompt and slow answers both occur
	always_ff @(posedge clk_i) begin
		valid_o <= 1'b0;
		data_o <= ~data_o; // stale data never looks valid
		if (start_i) begin
			cnt_r <= 3'(code_i[1:0]) + 3'h1;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
			valid_o <= cnt_r == 3'h1;
			if (cnt_r == 3'h1) data_o <= code_i;
		end
	end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic mclk_i, arst_n_i, step_req_i, dir_cw_i, limit_clockwise_i, adc_valid_i;
	logic limit_counter_clockwise_i, stop_n_i, overload_i, ana_rd_i, step_clk_o;
	logic step_taken_o, step_blocked_o, overload_o, prog_run_o, adc_start_o, ana_done_o;
	logic [5:0] ana_dig_i, dig_o;
	logic [2:0] ana_sel_i, adc_chan_o;
	logic [7:0] adc_data_i, ana_result_o, code;
	logic [31:0] position_o, exp_pos;
	logic [11:0] sum;
	int n_fail = 0;
	int check_count = 0;
	int w;
	slsl_step_limit_stop uut (.*);
	slsl_adc_model far (.clk_i(mclk_i), .start_i(adc_start_o), .code_i(code),
		.valid_o(adc_valid_i), .data_o(adc_data_i));
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	// fresh converter codes every cycle; the bench sums what it hands over
	always @(posedge mclk_i) code <= 8'($urandom);
	always @(posedge mclk_i) if (adc_valid_i) sum <= sum + 12'(adc_data_i);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// one request; expects it taken or not, then the position it leaves
	task automatic step(input logic ok, input logic blk = 1'b0);
		step_req_i <= 1'b1;
		@(posedge mclk_i) step_req_i <= 1'b0;
		#1 chk(step_taken_o, ok);
		chk(step_blocked_o, blk);
		if (ok) exp_pos = dir_cw_i ? exp_pos + 1 : exp_pos - 1;
		repeat (5) @(posedge mclk_i);
		chk(position_o, exp_pos);
	endtask
	initial begin
		{step_req_i, dir_cw_i, limit_clockwise_i, limit_counter_clockwise_i} = '0;
		{overload_i, ana_rd_i, ana_dig_i, ana_sel_i, arst_n_i, sum} = '0;
		stop_n_i = 1'b1;
		exp_pos = '0;
		void'($urandom(32'hce6d));
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		repeat (20) begin
			dir_cw_i <= 1'($urandom);
			@(posedge mclk_i);
			step(1'b1);
		end
		// each direction against each limit: only the leading one stops
		for (int i = 0; i < 4; i++) begin
			dir_cw_i <= i[0];
			limit_clockwise_i <= i[1];
			limit_counter_clockwise_i <= !i[1];
			repeat (3) @(posedge mclk_i);
			step(i[0] ^ i[1], !(i[0] ^ i[1]));
			chk(prog_run_o, 1'b1);
		end
		{limit_clockwise_i, limit_counter_clockwise_i, stop_n_i} <= '0;
		repeat (4) @(posedge mclk_i);
		chk(prog_run_o, 1'b0);
		step(1'b0, 1'b1);
		stop_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk(prog_run_o, 1'b1);
		step(1'b1);
		repeat (3) begin
			ana_dig_i <= 6'($urandom);
			ana_sel_i <= 3'($urandom % 6);
			ana_rd_i <= 1'b1;
			sum <= '0;
			@(posedge mclk_i) ana_rd_i <= 1'b0;
			w = 0;
			while (!ana_done_o && w < 2000) begin
				@(posedge mclk_i);
				w++;
			end
			chk(ana_done_o, 1'b1);
			chk(ana_result_o, sum >> 4);
			chk(dig_o, ana_dig_i);
			chk(adc_chan_o, ana_sel_i);
			if (!ana_done_o) report_and_stop();
		end
		// overload lands while a pulse is still high
		step_req_i <= 1'b1;
		@(posedge mclk_i) step_req_i <= 1'b0;
		overload_i <= 1'b1;
		@(posedge mclk_i) overload_i <= 1'b0;
		exp_pos = exp_pos + 1;
		repeat (5) @(posedge mclk_i);
		chk(overload_o, 1'b1);
		chk(step_clk_o, 1'b0);
		step(1'b0);
		arst_n_i <= 1'b0;
		@(posedge mclk_i) arst_n_i <= 1'b1;
		exp_pos = '0;
		chk(overload_o, 1'b0);
		step(1'b1);
		report_and_stop();
	end
endmodule
